// ---- verilog/rsc_defines.svh ----
// Constants of the reset strap configuration latch
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH

// Clock
`define RSC_CLK_MHZ            250
`define RSC_CLK_PERIOD_NS      4

// Reset pulse times in physical units
`define RSC_FULL_MIN_US        1.2
`define RSC_PART_MIN_NS        40
`define RSC_PART_MAX_NS        500

// Cycle counts (least times round up, longest rounds down)
`define RSC_FULL_MIN_CYC       ($rtoi($ceil(`RSC_FULL_MIN_US * `RSC_CLK_MHZ)))
`define RSC_PART_MIN_CYC       ((`RSC_PART_MIN_NS * `RSC_CLK_MHZ + 999) / 1000)
`define RSC_PART_MAX_CYC       ((`RSC_PART_MAX_NS * `RSC_CLK_MHZ) / 1000)

// Low-time counter width
`define RSC_CNT_W              9

// Strap encodings
`define RSC_RANGE_SW_MODE      2'h0
`define RSC_RANGE_NONE         2'h0
`define RSC_IFACE_PARALLEL     1'h0
`define RSC_IFACE_SERIAL       1'h1
`define RSC_REF_INTERNAL       1'h1
`define RSC_LANE_ONE_WIRE      1'h1
`define RSC_OS_NONE            3'h0

`endif

// ---- verilog/rsc_pkg.sv ----
// Types of the reset strap configuration latch
package rsc_pkg;

	// Strap pin levels
	typedef struct packed {
		logic [1:0] range_mode_straps;
		logic       reference_source_strap;
		logic       interface_type_strap;
		logic       serial_lane_count_strap;
		logic [2:0] os_strap;
		logic       crc_strap;
		logic       burst_strap;
		logic       seq_strap;
	} rsc_straps_type;

	// Converter settings that come from pins or registers
	typedef struct packed {
		logic [2:0] os_ratio;
		logic       crc_en;
		logic       burst_en;
		logic       seq_en;
	} rsc_cfg_type;

	// Functions available in the latched mode
	typedef struct packed {
		logic oversampling;
		logic crc;
		logic register_access;
		logic individual_ranges;
		logic configurable_sequencer;
		logic diagnostic_channels;
		logic serial_one_wire;
		logic serial_two_wire;
	} rsc_feature_type;

	typedef enum logic [3:0] {
		RSC_ST_UNCFG    = 4'h1,
		RSC_ST_SHUTDOWN = 4'h2,
		RSC_ST_HW       = 4'h4,
		RSC_ST_SW       = 4'h8
	} rsc_state_type;

endpackage

// ---- verilog/rsc_reset_meter.sv ----
// Measures reset pin low pulses and classifies them as full or partial
`timescale 1ns/1ps
`include "rsc_defines.svh"

module rsc_reset_meter
(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic reset,
	// Reset pin from host
	input  wire logic reset_pin_n,
	// Classification
	output logic      full_held,
	output logic      full_release,
	output logic      partial_release
);

	localparam logic [`RSC_CNT_W-1:0] FULL_CYC = `RSC_CNT_W'(`RSC_FULL_MIN_CYC);
	localparam logic [`RSC_CNT_W-1:0] PART_CYC = `RSC_CNT_W'(`RSC_PART_MIN_CYC);

	logic [`RSC_CNT_W-1:0] low_cnt_reg;
	logic                  full_held_reg;
	logic                  full_release_reg;
	logic                  partial_release_reg;

	// Saturating count of cycles spent low
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			low_cnt_reg <= `RSC_CNT_W'h0;
		else if (reset_pin_n)
			low_cnt_reg <= `RSC_CNT_W'h0;
		else if (low_cnt_reg < FULL_CYC)
			low_cnt_reg <= low_cnt_reg + `RSC_CNT_W'h1;
	end

	// Full reset reached while pin still low
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			full_held_reg <= 1'b0;
		else
			full_held_reg <= !reset_pin_n && (low_cnt_reg >= FULL_CYC - `RSC_CNT_W'h1);
	end

	// Release classification; short glitches are ignored
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			full_release_reg    <= 1'b0;
			partial_release_reg <= 1'b0;
		end
		else
		begin
			full_release_reg    <= reset_pin_n && (low_cnt_reg >= FULL_CYC);
			partial_release_reg <= reset_pin_n && (low_cnt_reg >= PART_CYC) && (low_cnt_reg < FULL_CYC);
		end
	end

	assign full_held       = full_held_reg;
	assign full_release    = full_release_reg;
	assign partial_release = partial_release_reg;

endmodule

// ---- verilog/rsc_config_latch.sv ----
// Reset strap configuration latch: mode, reference and interface selection
`timescale 1ns/1ps
`include "rsc_defines.svh"

module rsc_config_latch
(
	// Clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     reset,
	// Host pins
	input  wire logic                     reset_pin_n,
	input  wire rsc_pkg::rsc_straps_type  straps,
	// Settings held in the register file
	input  wire rsc_pkg::rsc_cfg_type     reg_cfg,
	// Register access requests
	input  wire logic                     reg_access_req,
	output logic                          reg_access_grant,
	output logic                          reg_access_refused,
	// Latched configuration
	output logic                          config_valid,
	output logic                          hw_mode,
	output logic                          sw_mode,
	output logic                          internal_ref_enable,
	output logic                          serial_interface,
	output logic                          serial_one_wire,
	output logic [1:0]                    common_range,
	output rsc_pkg::rsc_cfg_type          active_cfg,
	output rsc_pkg::rsc_feature_type      features,
	// Reset events for the rest of the converter
	output logic                          full_reset_active,
	output logic                          partial_reset_pulse
);

	rsc_pkg::rsc_state_type   state_reg;
	rsc_pkg::rsc_state_type   state_next;
	rsc_pkg::rsc_straps_type  straps_reg;
	rsc_pkg::rsc_cfg_type     hw_cfg_reg;
	rsc_pkg::rsc_cfg_type     active_cfg_reg;
	rsc_pkg::rsc_feature_type features_reg;
	rsc_pkg::rsc_feature_type features_next;
	logic                     full_held;
	logic                     full_release;
	logic                     partial_release;
	logic                     int_ref_reg;
	logic                     serial_reg;
	logic                     one_wire_reg;
	logic [1:0]               range_reg;
	logic                     hw_mode_reg;
	logic                     sw_mode_reg;
	logic                     valid_reg;
	logic                     grant_reg;
	logic                     refused_reg;
	logic                     full_active_reg;
	logic                     partial_pulse_reg;

	rsc_reset_meter u_meter
	(
		.sys_clk         (sys_clk),
		.reset           (reset),
		.reset_pin_n     (reset_pin_n),
		.full_held       (full_held),
		.full_release    (full_release),
		.partial_release (partial_release)
	);

	// Straps aligned with the meter's release pulse
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			straps_reg <= '0;
		else
			straps_reg <= straps;
	end

	// Mode state
	always_comb
	begin
		state_next = state_reg;
		if (full_held)
			state_next = rsc_pkg::RSC_ST_SHUTDOWN;
		else if (full_release)
		begin
			if (straps_reg.range_mode_straps == `RSC_RANGE_SW_MODE)
				state_next = rsc_pkg::RSC_ST_SW;
			else
				state_next = rsc_pkg::RSC_ST_HW;
		end
	end

	// Only a full reset moves the mode; partial resets leave it
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			state_reg <= rsc_pkg::RSC_ST_UNCFG;
		else
			state_reg <= state_next;
	end

	// Pin-latched settings, captured only at full reset release
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			int_ref_reg  <= 1'b0;
			serial_reg   <= 1'b0;
			one_wire_reg <= 1'b0;
			hw_cfg_reg   <= '0;
		end
		else if (full_held)
		begin
			int_ref_reg  <= 1'b0;
			serial_reg   <= 1'b0;
			one_wire_reg <= 1'b0;
			hw_cfg_reg   <= '0;
		end
		else if (full_release)
		begin
			int_ref_reg  <= straps_reg.reference_source_strap == `RSC_REF_INTERNAL;
			serial_reg   <= straps_reg.interface_type_strap == `RSC_IFACE_SERIAL;
			one_wire_reg <= (straps_reg.interface_type_strap == `RSC_IFACE_SERIAL)
				&& (straps_reg.serial_lane_count_strap == `RSC_LANE_ONE_WIRE);
			hw_cfg_reg   <= '{straps_reg.os_strap, straps_reg.crc_strap,
				straps_reg.burst_strap, straps_reg.seq_strap};
		end
	end

	// Availability matrix
	always_comb
	begin
		features_next = '0;
		unique case (state_reg)
			rsc_pkg::RSC_ST_SW:
			begin
				features_next = '1;
				features_next.serial_one_wire = serial_reg;
				features_next.serial_two_wire = serial_reg;
			end
			rsc_pkg::RSC_ST_HW:
			begin
				features_next.oversampling    = serial_reg;
				features_next.crc             = serial_reg;
				features_next.serial_one_wire = serial_reg;
				features_next.serial_two_wire = serial_reg;
			end
			rsc_pkg::RSC_ST_UNCFG,
			rsc_pkg::RSC_ST_SHUTDOWN:
				features_next = '0;
			default:
				features_next = '0;
		endcase
	end

	// Settings source and mode outputs
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			active_cfg_reg <= '0;
			range_reg      <= `RSC_RANGE_NONE;
			features_reg   <= '0;
			hw_mode_reg    <= 1'b0;
			sw_mode_reg    <= 1'b0;
			valid_reg      <= 1'b0;
		end
		else
		begin
			features_reg <= features_next;
			hw_mode_reg  <= state_reg == rsc_pkg::RSC_ST_HW;
			sw_mode_reg  <= state_reg == rsc_pkg::RSC_ST_SW;
			valid_reg    <= (state_reg == rsc_pkg::RSC_ST_HW) || (state_reg == rsc_pkg::RSC_ST_SW);
			if (state_reg == rsc_pkg::RSC_ST_HW)
			begin
				// Pins only; parallel hardware mode lacks oversampling and CRC
				active_cfg_reg          <= hw_cfg_reg;
				active_cfg_reg.os_ratio <= serial_reg ? hw_cfg_reg.os_ratio : `RSC_OS_NONE;
				active_cfg_reg.crc_en   <= serial_reg && hw_cfg_reg.crc_en;
				range_reg               <= straps_reg.range_mode_straps;
			end
			else if (state_reg == rsc_pkg::RSC_ST_SW)
			begin
				active_cfg_reg <= reg_cfg;
				range_reg      <= `RSC_RANGE_NONE;
			end
			else
			begin
				active_cfg_reg <= '0;
				range_reg      <= `RSC_RANGE_NONE;
			end
		end
	end

	// Register access gate
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			grant_reg   <= 1'b0;
			refused_reg <= 1'b0;
		end
		else
		begin
			grant_reg   <= reg_access_req && (state_reg == rsc_pkg::RSC_ST_SW);
			refused_reg <= reg_access_req && (state_reg != rsc_pkg::RSC_ST_SW);
		end
	end

	// Reset events
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			full_active_reg   <= 1'b0;
			partial_pulse_reg <= 1'b0;
		end
		else
		begin
			full_active_reg   <= state_next == rsc_pkg::RSC_ST_SHUTDOWN;
			partial_pulse_reg <= partial_release;
		end
	end

	assign config_valid        = valid_reg;
	assign hw_mode             = hw_mode_reg;
	assign sw_mode             = sw_mode_reg;
	assign internal_ref_enable = int_ref_reg;
	assign serial_interface    = serial_reg;
	assign serial_one_wire     = one_wire_reg;
	assign common_range        = range_reg;
	assign active_cfg          = active_cfg_reg;
	assign features            = features_reg;
	assign reg_access_grant    = grant_reg;
	assign reg_access_refused  = refused_reg;
	assign full_reset_active   = full_active_reg;
	assign partial_reset_pulse = partial_pulse_reg;

endmodule

// ---- tb/rsc_config_latch_monitor.sv ----
// Checker for the reset strap configuration latch
`timescale 1ns/1ps
module rsc_config_latch_monitor
(
	// Clock and reset
	input wire logic                     sys_clk,
	input wire logic                     reset,
	// Host side
	input wire logic                     reset_pin_n,
	input wire rsc_pkg::rsc_straps_type  straps,
	input wire rsc_pkg::rsc_cfg_type     reg_cfg,
	input wire logic                     reg_access_req,
	// Design outputs
	input wire logic                     reg_access_grant,
	input wire logic                     reg_access_refused,
	input wire logic                     config_valid,
	input wire logic                     hw_mode,
	input wire logic                     sw_mode,
	input wire logic                     internal_ref_enable,
	input wire logic                     serial_interface,
	input wire logic                     serial_one_wire,
	input wire logic [1:0]               common_range,
	input wire rsc_pkg::rsc_cfg_type     active_cfg,
	input wire rsc_pkg::rsc_feature_type features,
	input wire logic                     full_reset_active,
	input wire logic                     partial_reset_pulse
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	a_grant_in_sw: assert property (reg_access_req && sw_mode && reset_pin_n |=> reg_access_grant)
		else $error("grant missing in software mode");
	a_refuse_in_hw: assert property (reg_access_req && hw_mode && reset_pin_n |=> reg_access_refused && !reg_access_grant)
		else $error("access not refused in hardware mode");
	a_answer_has_cause: assert property (reg_access_grant || reg_access_refused |-> $past(reg_access_req))
		else $error("access answer without request");
	a_mode_exclusive: assert property (!(hw_mode && sw_mode))
		else $error("both modes active");
	a_mode_held: assert property (!$stable({hw_mode, sw_mode, internal_ref_enable, serial_interface, serial_one_wire})
		|-> full_reset_active || $past(full_reset_active) || $past(full_reset_active, 2) || $past(full_reset_active, 3))
		else $error("latched setting changed without full reset");
	a_range_zero_sw: assert property (sw_mode |-> common_range == 2'h0)
		else $error("range shown in software mode");
	a_range_live_hw: assert property (hw_mode && $past(hw_mode, 3) && $stable(straps.range_mode_straps)
		&& $past(straps.range_mode_straps) == $past(straps.range_mode_straps, 2)
		|-> common_range == $past(straps.range_mode_straps))
		else $error("range not following straps");
	a_wire_needs_serial: assert property (serial_one_wire |-> serial_interface)
		else $error("one-wire without serial");
	a_hw_par_bare: assert property (hw_mode && !$past(serial_interface) |-> features == 8'h00)
		else $error("features in hardware parallel mode");
	a_partial_keeps: assert property (partial_reset_pulse |=> $stable({hw_mode, sw_mode, config_valid, active_cfg}))
		else $error("partial reset changed configuration");
	a_shutdown_clears: assert property (full_reset_active |=> !config_valid)
		else $error("configuration kept during full reset");
	c_grant: cover property (reg_access_grant);
	c_hw_serial: cover property (hw_mode && serial_interface);
	c_partial: cover property (partial_reset_pulse);
endmodule

bind rsc_config_latch rsc_config_latch_monitor i_mon
(
	.sys_clk(sys_clk), .reset(reset), .reset_pin_n(reset_pin_n), .straps(straps), .reg_cfg(reg_cfg),
	.reg_access_req(reg_access_req), .reg_access_grant(reg_access_grant), .reg_access_refused(reg_access_refused),
	.config_valid(config_valid), .hw_mode(hw_mode), .sw_mode(sw_mode), .internal_ref_enable(internal_ref_enable),
	.serial_interface(serial_interface), .serial_one_wire(serial_one_wire), .common_range(common_range),
	.active_cfg(active_cfg), .features(features), .full_reset_active(full_reset_active),
	.partial_reset_pulse(partial_reset_pulse)
);

// ---- tb/rsc_host_model.sv ----
// Host controller model driving the reset pin and straps
`timescale 1ns/1ps
module rsc_host_model
(
	// Clock
	input wire logic                sys_clk,
	// Pins towards the converter
	output rsc_pkg::rsc_straps_type straps,
	output logic                    reset_pin_n
);
	// Pin low from power-up until supplies settle
	initial
	begin
		reset_pin_n = 1'h0;
		straps = '0;
	end
	task automatic hold(input int cyc);
		@(negedge sys_clk);
		reset_pin_n = 1'h0;
		repeat (cyc) @(negedge sys_clk);
	endtask
	task automatic release_pin(input rsc_pkg::rsc_straps_type s);
		straps = s;
		reset_pin_n = 1'h1;
	endtask
	task automatic set_straps(input rsc_pkg::rsc_straps_type s);
		@(negedge sys_clk);
		straps = s;
	endtask
endmodule

// ---- tb/rsc_config_latch_tb_top.sv ----
// Testbench for the reset strap configuration latch
`timescale 1ns/1ps
module rsc_config_latch_tb_top;
	logic                     sys_clk;
	logic                     reset;
	logic                     reset_pin_n;
	rsc_pkg::rsc_straps_type  straps;
	rsc_pkg::rsc_cfg_type     reg_cfg;
	rsc_pkg::rsc_cfg_type     active_cfg;
	rsc_pkg::rsc_feature_type features;
	logic                     reg_access_req;
	logic                     grant;
	logic                     refused;
	logic                     valid;
	logic                     hw;
	logic                     sw;
	logic                     iref;
	logic                     ser;
	logic                     one_w;
	logic [1:0]               crange;
	logic                     fra;
	logic                     ppulse;
	int                       n_fail;
	int                       num_checks;

	initial
	begin
		sys_clk = 1'h0;
		forever #2 sys_clk = ~sys_clk;
	end

	rsc_host_model i_host (.sys_clk(sys_clk), .straps(straps), .reset_pin_n(reset_pin_n));
	rsc_config_latch i_dut (.sys_clk(sys_clk), .reset(reset), .reset_pin_n(reset_pin_n), .straps(straps),
		.reg_cfg(reg_cfg), .reg_access_req(reg_access_req), .reg_access_grant(grant), .reg_access_refused(refused),
		.config_valid(valid), .hw_mode(hw), .sw_mode(sw), .internal_ref_enable(iref), .serial_interface(ser),
		.serial_one_wire(one_w), .common_range(crange), .active_cfg(active_cfg), .features(features),
		.full_reset_active(fra), .partial_reset_pulse(ppulse));

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic access(input logic ok);
		@(negedge sys_clk);
		reg_access_req = 1'h1;
		@(negedge sys_clk);
		reg_access_req = 1'h0;
		chk("grant_refused", {6'h00, ok, !ok}, {6'h00, grant, refused});
	endtask
	task automatic full_cfg(input rsc_pkg::rsc_straps_type s);
		i_host.hold(305);
		chk("full_active", 8'h01, {7'h00, fra});
		i_host.release_pin(s);
		repeat (4) @(negedge sys_clk);
		chk("valid", 8'h01, {7'h00, valid});
	endtask
	task automatic partial(input int n);
		logic seen;
		seen = 1'h0;
		i_host.hold(n);
		i_host.release_pin(straps);
		repeat (4)
		begin
			@(negedge sys_clk);
			seen = seen | ppulse;
		end
		chk("partial_pulse", 8'h01, {7'h00, seen});
	endtask
	task automatic t_software();
		full_cfg({2'h0, 1'h1, 1'h1, 1'h1, 3'h5, 1'h1, 1'h0, 1'h1});
		chk("modes", 8'h17, {3'h0, sw, hw, iref, ser, one_w});
		chk("features_sw_ser", 8'hFF, features);
		reg_cfg = 6'h2B;
		repeat (2) @(negedge sys_clk);
		chk("active_sw", 8'h2B, {2'h0, active_cfg});
		access(1'h1);
		access(1'h1);
		i_host.set_straps({2'h2, 1'h0, 1'h0, 1'h0, 3'h0, 1'h0, 1'h1, 1'h0});
		repeat (4) @(negedge sys_clk);
		chk("ignored", 8'h17, {1'h0, crange, sw, hw, iref, ser, one_w});
		partial(50);
		partial(299);
		chk("kept", 8'hF7, {active_cfg[1:0], sw, valid, hw, iref, ser, one_w});
		full_cfg({2'h0, 1'h0, 1'h0, 1'h1, 3'h0, 1'h0, 1'h0, 1'h0});
		chk("modes_par", 8'h10, {3'h0, sw, hw, iref, ser, one_w});
		chk("features_sw_par", 8'hFC, features);
		$display("test software done");
	endtask
	task automatic t_hardware();
		logic [1:0] r;
		logic       sr;
		logic       ln;
		for (int i = 0; i < 6; i++)
		begin
			r = 2'(i % 3 + 1);
			sr = (i > 2);
			ln = i[1];
			full_cfg({r, i[0], sr, ln, 3'h6, 1'h1, 1'h1, 1'h0});
			chk("modes_hw", {1'h0, r, 2'h1, i[0], sr, sr & ln}, {1'h0, crange, sw, hw, iref, ser, one_w});
			chk("features_hw", sr ? 8'hC3 : 8'h00, features);
			chk("active_hw", sr ? 8'h36 : 8'h02, {2'h0, active_cfg});
			access(1'h0);
		end
		reg_cfg = 6'h11;
		i_host.set_straps({2'h1, 1'h0, 1'h0, 1'h0, 3'h1, 1'h0, 1'h0, 1'h1});
		repeat (4) @(negedge sys_clk);
		chk("hw_live", 8'h36, {2'h0, active_cfg});
		chk("range_live", 8'h1E, {2'h0, crange, hw, iref, ser, one_w});
		$display("test hardware done");
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		#100000;
		n_fail++;
		$display("FAIL watchdog expected finish seen timeout");
		print_verdict();
	end

	initial
	begin
		n_fail = 0;
		num_checks = 0;
		reset = 1'h1;
		reg_access_req = 1'h0;
		reg_cfg = 6'h00;
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk);
		reset = 1'h0;
		chk("valid_up", 8'h00, {7'h00, valid});
		access(1'h0);
		$display("test power_up done");
		t_software();
		t_hardware();
		print_verdict();
	end
endmodule
